// file: pkg/serial_pkg.sv
// Shared constants and types for the serial channel buffer and timing block
`default_nettype none
package serial_pkg;
    // Register byte addresses
    localparam logic [4:0]  CTRL_ADDR  = 5'h00;
    localparam logic [4:0]  STAT_ADDR  = 5'h04;
    localparam logic [4:0]  TXD_ADDR   = 5'h08;
    localparam logic [4:0]  RXD_ADDR   = 5'h0c;
    localparam logic [4:0]  DIV_ADDR   = 5'h10;
    // Reset values
    localparam logic [9:0]  CTRL_RESET = 10'h000;
    localparam logic [15:0] DIV_RESET  = 16'h0010;
    // Control field positions; bits 1:0 hold the mode
    localparam int F_DBE   = 2;
    localparam int F_STOPS = 3;
    localparam int F_RXON  = 4;
    localparam int F_PE    = 5;
    localparam int F_EVEN  = 6;
    localparam int F_EXT   = 7;
    localparam int F_FALL  = 8;
    localparam int F_MSB   = 9;
    // Status field positions
    localparam int S_TXRUN   = 0;
    localparam int S_RXFULL  = 1;
    localparam int S_TXEMPTY = 2;
    localparam int S_OERR    = 3;
    localparam int S_PERR    = 4;
    localparam int S_FERR    = 5;
    // Modes and frame lengths
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_7     = 2'h1;
    localparam logic [1:0] MODE_8     = 2'h2;
    localparam logic [1:0] MODE_9     = 2'h3;
    localparam logic [3:0] BITS_7     = 4'h7;
    localparam logic [3:0] BITS_8     = 4'h8;
    localparam logic [3:0] BITS_9     = 4'h9;
    localparam logic [3:0] SHIFT_BITS = BITS_8;
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_START = 2'b01,
        TX_DATA  = 2'b10,
        TX_STOP  = 2'b11
    } tx_state_type;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } rx_state_type;
endpackage
`default_nettype wire

// file: src/serial_channel.sv
// Serial channel: async and shift modes with buffer status flags and event timing
//
// Functional notes
// RULE1: Async transmit sends one or two stop bits per stop_length_select.
// RULE2: Async receive always checks a single stop bit only.
// RULE3: Double buffered: rx_holding_full sets when a frame reaches the holding buffer.
// RULE4: Reading the receive buffer clears rx_holding_full.
// RULE5: Without double buffering rx_holding_full has no meaning.
// RULE6: Double buffered: tx_holding_empty sets when holding data enters the shifter.
// RULE7: Any write to the transmit buffer clears tx_holding_empty.
// RULE8: Without double buffering tx_holding_empty has no meaning.
// RULE9: Tx single or double per enable; rx double except internal-clock shift.
// RULE10: Async receive event at the middle of the first stop bit.
// RULE11: Async framing and overrun errors flagged at the stop bit middle.
// RULE12: Parity mismatch flagged at the parity bit middle; nine-bit has none.
// RULE13: Async, single buffered: transmit event just before the stop bit.
// RULE14: Async, double buffered: transmit event when data enters the shifter.
// RULE15: Shift, single buffered: rx, tx events and overrun at last shift edge.
// RULE16: Internal-clock shift, double buffered: receive event after holding read.
// RULE17: Shift, double buffered: receive event when last edge fills holding buffer.
// RULE18: Shift, double buffered: tx event at last edge and on shifter load.
// RULE19: External-clock shift: underrun on next active edge without new data; the code flags it only when double buffered.
// RULE20: Software leaves control alone while transferring or receive is enabled.
// RULE21: Software keeps receive_enable set while a frame is arriving.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module serial_channel
    import serial_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic [4:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        rxd_i,
    output logic             txd_o,
    input  wire logic        sclk_i,
    output logic             sclk_o,
    output logic             sclk_oe_n_o,
    output logic             rx_int_o,
    output logic             tx_int_o
);

    // Parity bit over a data word
    function automatic logic calc_par(input logic [8:0] d, input logic ev);
        calc_par = ev ? ^d : ~^d;
    endfunction

    logic [9:0]   ctrl_reg;
    logic [15:0]  div_reg;
    logic         rxd_m, rxd_s, sclk_m, sclk_s, sclk_d;
    logic [1:0]   mode;
    logic         shift_mode, dbe, ext, par_on, receive_enable, msb;
    logic [3:0]   nbits, dbits;
    logic [8:0]   dmask;
    logic         wr_ctrl, wr_div, tx_wr, rxd_rd, st_rd;
    logic [15:0]  stat_word;
    // Shift clock engine
    logic [15:0]  sh_cnt;
    logic         sclk_reg, int_run, int_tick, act_edge, word_done;
    logic [3:0]   sh_bit;
    logic         und_armed, und_event;
    // Transmit path
    tx_state_type tx_state;
    logic [8:0]   tx_hold_reg, tx_data;
    logic [9:0]   tx_sh_reg, tx_frame;
    logic [15:0]  tx_cnt;
    logic [3:0]   tx_left;
    logic         tx_empty_reg, tx_loaded, tx_stop2, tx_tick;
    logic         tx_xfer, tx_load, tx_int_next;
    // Receive path
    rx_state_type rx_state;
    logic [15:0]  rx_cnt;
    logic [3:0]   rx_left;
    logic [8:0]   rx_sh, rx_hold_reg, rx_pend_data, rx_word;
    logic         rx_tick, rx_full_reg, rx_pend_reg, rx_stop_tick, par_tick;
    logic         rx_done, stall, rx_move;
    logic         oerr_reg, perr_reg, ferr_reg;

    // Control field decode
    assign mode       = ctrl_reg[1:0];
    assign shift_mode = (mode == MODE_SHIFT);
    assign dbe        = ctrl_reg[F_DBE];
    assign ext        = ctrl_reg[F_EXT];
    assign receive_enable        = ctrl_reg[F_RXON];
    assign msb        = ctrl_reg[F_MSB] && shift_mode;
    assign par_on     = ctrl_reg[F_PE] && (mode == MODE_7 || mode == MODE_8);
    assign dbits      = (mode == MODE_7) ? BITS_7 : (mode == MODE_9) ? BITS_9 : BITS_8;
    assign nbits      = dbits + {3'h0, par_on};
    assign dmask      = 9'h1ff >> (BITS_9 - dbits);

    // Register strobes
    assign wr_ctrl = wr_i && addr_i == CTRL_ADDR;
    assign wr_div  = wr_i && addr_i == DIV_ADDR;
    assign tx_wr   = wr_i && addr_i == TXD_ADDR;
    assign rxd_rd  = rd_i && addr_i == RXD_ADDR;
    assign st_rd   = rd_i && addr_i == STAT_ADDR;

    // Software settings; a zero divisor is not guarded and the bit timers wrap to a 65536-cycle bit time
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= CTRL_RESET;
            div_reg  <= DIV_RESET;
        end else begin
            if (wr_ctrl) ctrl_reg <= wdata_i[9:0];
            if (wr_div) div_reg <= wdata_i;
        end
    end

    // Status word
    always_comb begin
        stat_word            = 16'h0000;
        stat_word[S_TXRUN]   = tx_loaded;
        stat_word[S_RXFULL]  = rx_full_reg;
        stat_word[S_TXEMPTY] = tx_empty_reg;
        stat_word[S_OERR]    = oerr_reg;
        stat_word[S_PERR]    = perr_reg;
        stat_word[S_FERR]    = ferr_reg;
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !rd_i) begin
            rdata_o <= 16'h0000;
        end else begin
            case (addr_i)
                CTRL_ADDR: rdata_o <= {6'h00, ctrl_reg};
                STAT_ADDR: rdata_o <= stat_word;
                RXD_ADDR:  rdata_o <= {7'h00, rx_hold_reg};
                DIV_ADDR:  rdata_o <= div_reg;
                default:   rdata_o <= 16'h0000;
            endcase
        end
    end

    // Pin synchronisers; idle line levels are high
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rxd_m  <= 1'b1;
            rxd_s  <= 1'b1;
            sclk_m <= 1'b1;
            sclk_s <= 1'b1;
            sclk_d <= 1'b1;
        end else begin
            rxd_m  <= rxd_i;
            rxd_s  <= rxd_m;
            sclk_m <= sclk_i;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
        end
    end

    // Internal shift clock halts while a word waits for the holding buffer
    assign int_run  = shift_mode && !ext && (tx_loaded || receive_enable) && !rx_pend_reg; // RULE16 RULE21
    assign int_tick = (sh_cnt == 16'h0001);
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sh_cnt   <= 16'h0000;
            sclk_reg <= 1'b1;
        end else if (!int_run) begin
            sh_cnt   <= div_reg;
            sclk_reg <= 1'b1;
        end else if (int_tick) begin
            sh_cnt   <= div_reg;
            sclk_reg <= ~sclk_reg;
        end else begin
            sh_cnt <= sh_cnt - 16'h0001;
        end
    end
    assign sclk_o      = sclk_reg;
    assign sclk_oe_n_o = !(shift_mode && !ext);

    // Active edge: internal rising, or the selected external edge
    always_comb begin
        if (!shift_mode)
            act_edge = 1'b0;
        else if (ext)
            act_edge = (receive_enable || tx_loaded) &&
                       (ctrl_reg[F_FALL] ? (!sclk_s && sclk_d) : (sclk_s && !sclk_d)); // RULE15
        else
            act_edge = int_run && int_tick && !sclk_reg; // RULE15
    end
    assign word_done = act_edge && sh_bit == SHIFT_BITS - 4'h1;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !shift_mode)
            sh_bit <= 4'h0;
        else if (act_edge)
            sh_bit <= word_done ? 4'h0 : sh_bit + 4'h1;
    end

    // Underrun watch: a finished word arms it, the next edge checks for data
    assign und_event = ext && dbe && act_edge && und_armed && !tx_loaded; // RULE19
    always_ff @(posedge clock_i) begin
        if (sys_rst_i)
            und_armed <= 1'b0;
        else if (act_edge)
            und_armed <= word_done && tx_loaded;
    end

    // Holding to shifter move; single buffered writes while busy are dropped
    assign tx_xfer = dbe && !tx_empty_reg && !tx_loaded; // RULE6 RULE9
    assign tx_load = tx_xfer || (!dbe && tx_wr && !tx_loaded); // RULE9
    assign tx_data = tx_xfer ? tx_hold_reg : wdata_i[8:0];

    // Frame word with parity placed just above the data bits
    always_comb begin
        tx_frame = {1'b0, tx_data & dmask};
        if (par_on)
            tx_frame[dbits] = calc_par(tx_data & dmask, ctrl_reg[F_EVEN]);
    end

    // Transmit holding buffer and its empty flag; a same-cycle write refills it
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            tx_hold_reg  <= 9'h000;
            tx_empty_reg <= 1'b1;
        end else begin
            if (tx_wr && dbe) tx_hold_reg <= wdata_i[8:0];
            if (tx_wr)
                tx_empty_reg <= 1'b0; // RULE7 RULE8
            else if (tx_xfer || !dbe)
                tx_empty_reg <= 1'b1; // RULE6
        end
    end

    // Transmit sequencer for both async frames and shift words
    assign tx_tick = (tx_cnt == 16'h0001);
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            tx_state  <= TX_IDLE;
            txd_o     <= 1'b1;
            tx_cnt    <= 16'h0000;
            tx_left   <= 4'h0;
            tx_sh_reg <= 10'h000;
            tx_loaded <= 1'b0;
            tx_stop2  <= 1'b0;
        end else begin
            tx_cnt <= tx_cnt - 16'h0001;
            unique case (tx_state)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_sh_reg <= tx_frame;
                        tx_loaded <= 1'b1;
                        tx_left   <= nbits;
                        tx_cnt    <= div_reg;
                        tx_state  <= shift_mode ? TX_DATA : TX_START;
                        txd_o     <= shift_mode ? (msb ? tx_frame[7] : tx_frame[0]) : 1'b0;
                    end
                end
                TX_START: begin
                    if (tx_tick) begin
                        tx_state <= TX_DATA;
                        txd_o    <= tx_sh_reg[0];
                        tx_cnt   <= div_reg;
                    end
                end
                TX_DATA: begin
                    if (shift_mode ? act_edge : tx_tick) begin
                        tx_cnt  <= div_reg;
                        tx_left <= tx_left - 4'h1;
                        if (tx_left == 4'h1) begin
                            tx_state  <= shift_mode ? TX_IDLE : TX_STOP;
                            tx_loaded <= !shift_mode;
                            tx_stop2  <= ctrl_reg[F_STOPS]; // RULE1
                            txd_o     <= 1'b1;
                        end else if (msb) begin
                            tx_sh_reg <= {tx_sh_reg[8:0], 1'b0};
                            txd_o     <= tx_sh_reg[6];
                        end else begin
                            tx_sh_reg <= {1'b0, tx_sh_reg[9:1]};
                            txd_o     <= tx_sh_reg[1];
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_tick) begin
                        tx_cnt <= div_reg;
                        if (tx_stop2) begin
                            tx_stop2 <= 1'b0; // RULE1
                        end else begin
                            tx_state  <= TX_IDLE;
                            tx_loaded <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // Transmit events
    assign tx_int_next = tx_xfer || // RULE14 RULE18
        (!shift_mode && !dbe && tx_state == TX_DATA && tx_tick && tx_left == 4'h1) || // RULE13
        (shift_mode && tx_state == TX_DATA && act_edge && tx_left == 4'h1); // RULE15 RULE18

    // Async receiver; shift mode samples on active edges while idle here
    assign rx_tick = (rx_cnt == 16'h0001);
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rx_state <= RX_IDLE;
            rx_cnt   <= 16'h0000;
            rx_left  <= 4'h0;
            rx_sh    <= 9'h000;
        end else begin
            rx_cnt <= rx_cnt - 16'h0001;
            unique case (rx_state)
                RX_IDLE: begin
                    if (act_edge)
                        rx_sh <= msb ? {rx_sh[7:0], rxd_s} : {rxd_s, rx_sh[8:1]};
                    else if (!shift_mode && receive_enable && !rxd_s) begin
                        rx_state <= RX_START;
                        rx_cnt   <= {1'b0, div_reg[15:1]};
                        rx_sh    <= 9'h000;
                        rx_left  <= nbits;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        rx_state <= rxd_s ? RX_IDLE : RX_DATA;
                        rx_cnt   <= div_reg;
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rx_sh   <= {rxd_s, rx_sh[8:1]};
                        rx_cnt  <= div_reg;
                        rx_left <= rx_left - 4'h1;
                        if (rx_left == 4'h1) rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_tick) rx_state <= RX_IDLE; // RULE2
                end
            endcase
        end
    end

    // Completion events and word alignment
    assign rx_stop_tick = rx_state == RX_STOP && rx_tick; // RULE10 RULE11
    assign par_tick     = par_on && rx_state == RX_DATA && rx_tick && rx_left == 4'h1; // RULE12
    assign rx_done      = rx_stop_tick || word_done;
    always_comb begin
        if (shift_mode)
            rx_word = msb ? {1'b0, rx_sh[6:0], rxd_s} : {1'b0, rxd_s, rx_sh[8:2]};
        else
            rx_word = (rx_sh >> (BITS_9 - nbits)) & dmask;
    end
    // Internal clock with double buffering waits rather than overruns
    assign stall   = shift_mode && !ext && dbe && rx_full_reg && !rxd_rd; // RULE9 RULE16
    assign rx_move = (rx_done && !stall) || (rx_pend_reg && rxd_rd); // RULE16 RULE17

    // Holding buffer, its full flag and the parked word
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rx_hold_reg  <= 9'h000;
            rx_full_reg  <= 1'b0;
            rx_pend_reg  <= 1'b0;
            rx_pend_data <= 9'h000;
        end else begin
            if (rx_move) rx_hold_reg <= rx_pend_reg ? rx_pend_data : rx_word;
            if (rx_move)
                rx_full_reg <= 1'b1; // RULE3 RULE5
            else if (rxd_rd)
                rx_full_reg <= 1'b0; // RULE4
            if (rx_done && stall) begin
                rx_pend_reg  <= 1'b1;
                rx_pend_data <= rx_word;
            end else if (rxd_rd) begin
                rx_pend_reg <= 1'b0;
            end
        end
    end

    // Error flags: hardware set wins over the clear from a status read
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            oerr_reg <= 1'b0;
            perr_reg <= 1'b0;
            ferr_reg <= 1'b0;
        end else begin
            if (rx_done && !stall && rx_full_reg && !rxd_rd)
                oerr_reg <= 1'b1; // RULE11 RULE15
            else if (st_rd)
                oerr_reg <= 1'b0;
            if ((par_tick && rxd_s != calc_par(rx_sh, ctrl_reg[F_EVEN])) || und_event)
                perr_reg <= 1'b1; // RULE12 RULE19
            else if (st_rd)
                perr_reg <= 1'b0;
            if (rx_stop_tick && !rxd_s)
                ferr_reg <= 1'b1; // RULE11
            else if (st_rd)
                ferr_reg <= 1'b0;
        end
    end

    // Event pulses, registered
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rx_int_o <= 1'b0;
            tx_int_o <= 1'b0;
        end else begin
            rx_int_o <= rx_move; // RULE10 RULE15 RULE17
            tx_int_o <= tx_int_next;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    rx_full_set_a: assert property (rx_move |=> rx_full_reg && rx_int_o) // RULE3
        else $error("holding full flag or rx event missing");
    rx_full_clr_a: assert property (rxd_rd && !rx_move |=> !rx_full_reg) // RULE4
        else $error("holding full flag not cleared by read");
    tx_empty_set_a: assert property (tx_xfer && !tx_wr |=> tx_empty_reg && tx_int_o && tx_loaded) // RULE6
        else $error("holding empty flag not set on move");
    tx_empty_clr_a: assert property (tx_wr |=> !tx_empty_reg) // RULE7
        else $error("holding empty flag not cleared by write");
    stop_length_a: assert property (!shift_mode && tx_state == TX_DATA && tx_tick && tx_left == 4'h1
        |=> tx_state == TX_STOP && txd_o && tx_stop2 == $past(ctrl_reg[F_STOPS])) // RULE1
        else $error("stop bit length wrong");
    tx_stop_event_a: assert property ($rose(tx_state == TX_STOP) && !dbe |-> tx_int_o) // RULE13
        else $error("tx event missing before stop bit");
    rx_single_stop_a: assert property (rx_stop_tick |=> rx_state == RX_IDLE ##0 rx_int_o == !$past(stall)) // RULE2
        else $error("receiver did not end at first stop bit");
    framing_flag_a: assert property (rx_stop_tick && !rxd_s |=> ferr_reg) // RULE11
        else $error("framing error not flagged");
    underrun_flag_a: assert property (und_event |=> perr_reg) // RULE19
        else $error("underrun not flagged");
    shift_last_a: assert property (word_done && tx_state == TX_DATA |=> tx_int_o && !tx_loaded) // RULE15
        else $error("tx event missing at last shift edge");

    async_frame_c: cover property (rx_stop_tick ##1 rx_int_o);
    double_tx_c: cover property (tx_xfer ##[1:400] tx_wr);
    shift_word_c: cover property (word_done && tx_loaded);
    stall_read_c: cover property (rx_pend_reg && rxd_rd);

endmodule
`default_nettype wire

// file: dv/serial_peer.sv
// Remote serial device: async frames and external shift clock
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(parameter int DIV = 4) (
    input  wire logic clock_i,
    input  wire logic txd_i,
    input  wire logic sclk_i,
    output logic      rxd_o,
    output logic      sclk_o
);
    // Line idles high; shift clock stands still outside words
    initial begin
        rxd_o = 1'b1;
        sclk_o = 1'b1;
    end
    // Start, n bits LSB first, then one stop bit of level stp
    task automatic send(input logic [9:0] b, input int n, input logic stp);
        logic [11:0] f;
        f = {1'b1, b, 1'b0};
        f[n+1] = stp;
        for (int i = 0; i <= n + 1; i++) begin
            rxd_o <= f[i];
            repeat (DIV) @(posedge clock_i);
        end
        // A low stop is released so the next frame sees an edge
        if (!stp) begin
            rxd_o <= 1'b1;
            @(posedge clock_i);
        end
    endtask
    // Mid-bit sampling of a frame from the block; ts marks its start
    task automatic get(output logic [7:0] d, output realtime ts);
        @(negedge txd_i);
        ts = $realtime;
        repeat (DIV / 2) @(posedge clock_i);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clock_i);
            d[i] = txd_i;
        end
    endtask
    // Block drives the clock: data is steady at each falling edge
    task automatic get_int(output logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(negedge sclk_i);
            d[i] = txd_i;
        end
    endtask
    // External clock, 200 ns period, rising edge active
    task automatic ext(input logic [7:0] din, input int n, output logic [7:0] dout);
        for (int i = 0; i < n; i++) begin
            sclk_o <= 1'b0;
            rxd_o <= din[i%8];
            #100;
            if (i < 8) dout[i] = txd_i;
            sclk_o <= 1'b1;
            #100;
        end
        rxd_o <= ~rxd_o;
    endtask
endmodule
`default_nettype wire

// file: dv/serial_buffer_status_event_timing_test.sv
// Bench for the serial channel buffer flags and event timing
`timescale 1ns/1ps
`default_nettype none
module serial_buffer_status_event_timing_test;
    import serial_pkg::*;
    localparam int DIV = 4;
    logic        clock_i, sys_rst_i, wr_i, rd_i, rxd, txd_o, sclk_p, sclk_o, sclk_oe_n_o, rx_int_o, tx_int_o;
    logic [4:0]  addr_i;
    logic [15:0] wdata_i, rdata_o, v;
    logic [7:0]  g, h;
    wire logic   sclk_w = sclk_oe_n_o ? sclk_p : sclk_o;
    int          n_mismatch = 0, cmp_count = 0, n_rx = 0, n_tx = 0, cyc = 0, rx_at = 0, c0, k, lat;
    realtime     t0, t1;
    serial_channel u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd), .txd_o(txd_o), .sclk_i(sclk_w),
        .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n_o), .rx_int_o(rx_int_o), .tx_int_o(tx_int_o));
    serial_peer #(.DIV(DIV)) u_peer (.clock_i(clock_i), .txd_i(txd_o), .sclk_i(sclk_w), .rxd_o(rxd),
        .sclk_o(sclk_p));
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    // Event pulses counted; receive event cycle kept for latency
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (rx_int_o === 1'b1) begin
            n_rx <= n_rx + 1;
            rx_at <= cyc;
        end
        if (tx_int_o === 1'b1) n_tx <= n_tx + 1;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        #1;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stat(input logic [15:0] e, input string what);
        logic [15:0] s;
        repeat (DIV) @(posedge clock_i);
        rd(STAT_ADDR, s);
        check(s & 16'h003a, e, what);
    endtask
    // Control only changes with reception off, then enable goes last
    task automatic setc(input logic [15:0] c);
        wr(CTRL_ADDR, c & ~(16'h1 << F_RXON));
        wr(CTRL_ADDR, c);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Run needs under 100 us
    initial begin
        #300000;
        n_mismatch++;
        results();
    end
    initial begin
        sys_rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 5'h00;
        wdata_i = 16'h0000;
        repeat (16) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        stat(16'h0000, "flags after reset");
        rd(STAT_ADDR, v);
        check(v, 16'h0004, "status reset");
        rd(DIV_ADDR, v);
        check(v, DIV_RESET, "divider reset");
        wr(5'h14, 16'hffff);
        rd(5'h14, v);
        check(v, 16'h0000, "unmapped read");
        wr(DIV_ADDR, 16'(DIV));
        $display("test reset done");
        // Double buffered words back to back, both stop lengths
        for (int s = 0; s < 2; s++) begin
            k = n_tx;
            setc(16'(MODE_8) | (16'h1 << F_DBE) | (16'(s) << F_STOPS));
            fork
                begin
                    u_peer.get(g, t0);
                    u_peer.get(h, t1);
                end
                begin
                    wr(TXD_ADDR, 16'h005a);
                    repeat (3) @(posedge clock_i);
                    wr(TXD_ADDR, 16'h00c3);
                    rd(STAT_ADDR, v);
                    check(16'(v[S_TXEMPTY]), 16'h0000, "holding empty");
                end
            join
            check({g, h}, 16'h5ac3, "async words");
            check(16'(int'((t1 - t0) / 25.0)), 16'((10 + s) * DIV + 1), "frame spacing");
            repeat (12 * DIV) @(posedge clock_i);
            check(16'(n_tx - k), 16'h0002, "tx events");
        end
        setc(16'(MODE_8));
        wr(TXD_ADDR, 16'h0011);
        repeat (44) @(posedge clock_i);
        check(16'(n_tx - k), 16'h0003, "single tx");
        $display("test async transmit done");
        setc(16'(MODE_8) | (16'h1 << F_RXON));
        c0 = cyc;
        u_peer.send(10'h0a5, 8, 1'b1);
        stat(16'h0002, "full after frame");
        lat = rx_at - c0;
        check(16'(lat >= 9 * DIV + DIV / 2 && lat <= 9 * DIV + DIV / 2 + 7), 16'h0001, "rx event time");
        rd(RXD_ADDR, v);
        check(v, 16'h00a5, "rx word");
        stat(16'h0000, "cleared by read");
        fork
            begin
                u_peer.send(10'h03c, 8, 1'b1);
                u_peer.send(10'h071, 8, 1'b1);
            end
            begin
                repeat (11 * DIV) @(posedge clock_i);
                rd(RXD_ADDR, v);
                check(v, 16'h003c, "first of pair");
            end
        join
        stat(16'h0002, "single stop accepted");
        rd(RXD_ADDR, v);
        check(v, 16'h0071, "second of pair");
        u_peer.send(10'h055, 8, 1'b0);
        stat(16'h0022, "framing error");
        rd(RXD_ADDR, v);
        setc(16'(MODE_8) | (16'h1 << F_RXON) | (16'h1 << F_PE) | (16'h1 << F_EVEN));
        u_peer.send(10'h001, 9, 1'b1);
        stat(16'h0012, "parity error");
        rd(RXD_ADDR, v);
        u_peer.send(10'h011, 9, 1'b1);
        u_peer.send(10'h022, 9, 1'b1);
        stat(16'h000a, "overrun");
        rd(RXD_ADDR, v);
        rd(RXD_ADDR, v);
        $display("test async receive done");
        k = n_tx;
        setc(16'(MODE_SHIFT));
        fork
            u_peer.get_int(g);
            wr(TXD_ADDR, 16'h0096);
        join
        repeat (8) @(posedge clock_i);
        check(16'(sclk_oe_n_o), 16'h0000, "clock driven");
        check(16'(g), 16'h0096, "shift word");
        check(16'(n_tx - k), 16'h0001, "shift tx event");
        rd(RXD_ADDR, v);
        k = n_tx;
        c0 = n_rx;
        setc(16'(MODE_SHIFT) | (16'h1 << F_DBE) | (16'h1 << F_EXT) | (16'h1 << F_RXON));
        wr(TXD_ADDR, 16'h003c);
        u_peer.ext(8'hd2, 9, h);
        repeat (8) @(posedge clock_i);
        check(16'(h), 16'h003c, "ext tx word");
        check(16'(n_rx - c0), 16'h0001, "ext rx event");
        check(16'(n_tx - k), 16'h0002, "ext tx events");
        stat(16'h0012, "full and underrun");
        rd(RXD_ADDR, v);
        check(v, 16'h00d2, "ext rx word");
        $display("test shift done");
        results();
    end
endmodule
`default_nettype wire
